//--- hdl/ssp_top.sv
// sync sleep pulse controller: apb registers, sleep cycle, pulse pin, button and led
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "ssp_defines.svh"

// Notes on behaviour
// [R1] sleep-immediate command sleeps this node now and broadcasts sleep to all
// [R2] early sleep lasts rest of wake plus sleep time; cycle unchanged
// [R3] a node missing the sleep broadcast just keeps its normal cycle
// [R4] pin function 6 drives pin low then high at each sync point
// [R5] pin shows either on-sleep indicator (function 1) or pulse, never both
// [R6] pulse still made when sleeping network; no transmit while asleep
// [R7] sync messages and pulse only with sleep mode 7 or 8
// [R8] sleep period 0 keeps the network awake even in mode 8
// [R9] wake time sets pulse interval, raised to traversal minimum
// [R10] pulse alignment typically within 100 us, not guaranteed
// [R11] after reset the node runs normal, non-sleeping mode
// [R12] sleep options bit set to 1 makes node preferred coordinator
// [R13] double button press makes node emit syncs as coordinator
// [R14] coordinator blinks the association led slowly
// [R15] led blinks whenever node is awake and synchronized
// [R16] single press wakes a synchronized sleeping node
// [R17] unsynced node repeats sync request then sleeps its sleep period
// [R18] any awake node answers a sync request with a sync; code answers only when synced in mode 7 or 8
// [R19] sleep-support nodes never sleep
// [R20] two second button hold wakes a cyclic-sleep node
// [R21] long-press wake lasts 30 seconds, answering sync requests
// [R22] a received sync sets sleep period and wake time
// [R23] mode 7 is always-awake support, mode 8 cyclic sleep
// [R24] pulse low phase lasts a fixed number of clock cycles
module ssp_top #(
    parameter int MS_CYCLES = `SSP_TICK_CYCLES
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // peer messages over the radio
    input  wire ssp_pkg::ssp_msg_t rx_msg,
    output ssp_pkg::ssp_msg_t      tx_msg,
    output logic                   tx_enable,
    // pins
    input  wire logic              commission_btn,
    output logic                   assoc_led,
    output logic                   sleep_indicator_pin
);

    // cycles from the end of the eight checked low cycles to the pin's return high
    localparam int PULSE_HI_DLY = `SSP_PULSE_LOW_CYC - 7;

    ssp_pkg::ssp_ctrl_t  ctrl_reg, ctrl_next;
    logic [15:0]         sp_reg, sp_next, st_reg, st_next, minw_reg, minw_next;
    logic [31:0]         prdata_reg, prdata_next;
    logic                slverr_reg, slverr_next, cmd_sleep;
    logic [15:0]         tick_reg, tick_next;
    logic                tick;
    ssp_pkg::ssp_state_t state_reg, state_next;
    logic [16:0]         phase_reg, phase_next, period;
    logic                early_reg, early_next, nom_reg, nom_next;
    logic [14:0]         forced_reg, forced_next;
    ssp_pkg::ssp_msg_t   tx_reg, tx_next;
    logic                txen_reg;
    logic [15:0]         st_eff;
    logic                mode_ok, mode_sup, mode_cyc, sp0, in_wake, awake, coord, synced;
    logic                adopt, period_end, sync_pt, imm_ok;
    logic                btn_prev_reg;
    logic [11:0]         hold_reg, hold_next;
    logic [1:0]          press_reg, press_next;
    logic [8:0]          gap_reg, gap_next;
    logic                btn_long, btn_single, btn_double;
    logic [5:0]          pulse_reg, pulse_next;
    logic                pin_reg, pin_next, led_reg, led_next, blink_on;
    logic [9:0]          led_cnt_reg, led_cnt_next, led_lim;

    // ==================================================
    // decode
    assign mode_sup   = ctrl_reg.sleep_mode_select == `SSP_MODE_SUPPORT;     // R23
    assign mode_cyc   = ctrl_reg.sleep_mode_select == `SSP_MODE_CYCLIC;      // R23
    assign mode_ok    = mode_sup | mode_cyc;                                 // R7
    assign st_eff     = (st_reg < minw_reg) ? minw_reg : st_reg;             // R9
    assign sp0        = sp_reg == 16'h0000;
    assign period     = {1'b0, st_eff} + {1'b0, sp_reg};
    assign in_wake    = phase_reg < {1'b0, st_eff};
    assign synced     = state_reg == ssp_pkg::ST_SYNCED;
    assign coord      = synced & (ctrl_reg.pref_coord | nom_reg);            // R12 R13
    assign tick       = tick_reg == 16'(MS_CYCLES - 1);
    assign adopt      = rx_msg.sync & awake & mode_ok & !coord;              // R22
    assign period_end = tick & (phase_reg >= period - 17'h0_0001);
    // the sync point is the phase wrap with no extra latency, so node skew
    // stays that of the incoming sync, typically 100 us
    assign sync_pt    = period_end | adopt;                                  // R10
    assign imm_ok     = cmd_sleep & synced & mode_cyc & !sp0;                // R1

    always_comb begin
        case (state_reg)
            ssp_pkg::ST_NORMAL: awake = 1'b1;                                // R11
            ssp_pkg::ST_SYNCED: awake = mode_sup | sp0 | (in_wake & !early_reg)
                                        | (forced_reg != 15'h0000);          // R19 R8 R2
            ssp_pkg::ST_SEARCH: awake = mode_sup | sp0 | in_wake
                                        | (forced_reg != 15'h0000);          // R17
            default:            awake = 1'b1;
        endcase
    end

    // ==================================================
    // apb slave: read data latched in setup, writes taken and the answer given in the access cycle
    assign pready  = penable;
    assign prdata  = prdata_reg;
    assign pslverr = slverr_reg;

    always_comb begin
        ctrl_next   = ctrl_reg;
        sp_next     = sp_reg;
        st_next     = st_reg;
        minw_next   = minw_reg;
        prdata_next = prdata_reg;
        slverr_next = slverr_reg;
        cmd_sleep   = 1'b0;
        if (psel && !penable) begin
            slverr_next = 1'b0;
            prdata_next = 32'h0000_0000;
            case (paddr)
                `SSP_ADDR_CTRL:      prdata_next = {23'h00_0000, ctrl_reg};
                `SSP_ADDR_SLEEP_PER: prdata_next = {16'h0000, sp_reg};
                `SSP_ADDR_WAKE_TIME: prdata_next = {16'h0000, st_eff};
                `SSP_ADDR_MIN_WAKE:  prdata_next = {16'h0000, minw_reg};
                `SSP_ADDR_CMD:       prdata_next = 32'h0000_0000;
                `SSP_ADDR_STATUS:    prdata_next = {28'h000_0000, forced_reg != 15'h0000,
                                                    coord, synced, awake};
                default:             slverr_next = 1'b1;
            endcase
        end
        if (psel && penable && pwrite) begin
            case (paddr)
                `SSP_ADDR_CTRL:      ctrl_next = ssp_pkg::ssp_ctrl_t'(pwdata[8:0]);
                `SSP_ADDR_SLEEP_PER: sp_next   = pwdata[15:0];
                `SSP_ADDR_WAKE_TIME: st_next   = pwdata[15:0];
                `SSP_ADDR_MIN_WAKE:  minw_next = pwdata[15:0];
                `SSP_ADDR_CMD:       cmd_sleep = pwdata[`SSP_CMD_SLEEP_BIT];
                default:             cmd_sleep = 1'b0;
            endcase
        end
        // a received sync overrides a software write in the same cycle
        if (adopt) begin
            sp_next = rx_msg.sleep_period;                                   // R22
            st_next = rx_msg.wake_time;                                      // R22
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg   <= '0;                                                // R11
            sp_reg     <= 16'h0000;
            st_reg     <= 16'h0000;
            minw_reg   <= `SSP_RST_MIN_WAKE;
            prdata_reg <= 32'h0000_0000;
            slverr_reg <= 1'b0;
        end else begin
            ctrl_reg   <= ctrl_next;
            sp_reg     <= sp_next;
            st_reg     <= st_next;
            minw_reg   <= minw_next;
            prdata_reg <= prdata_next;
            slverr_reg <= slverr_next;
        end
    end

    // ==================================================
    // millisecond timebase
    always_comb begin
        tick_next = tick ? 16'h0000 : tick_reg + 16'h0001;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_reg <= 16'h0000;
        end else begin
            tick_reg <= tick_next;
        end
    end

    // ==================================================
    // sleep cycle, sync messages, forced wake
    always_comb begin
        state_next  = state_reg;
        phase_next  = phase_reg;
        early_next  = early_reg;
        nom_next    = nom_reg;
        forced_next = forced_reg;
        tx_next     = '0;
        case (state_reg)
            ssp_pkg::ST_NORMAL: state_next = ssp_pkg::ST_SEARCH;
            ssp_pkg::ST_SEARCH: if (adopt || ctrl_reg.pref_coord || nom_reg) begin
                state_next = ssp_pkg::ST_SYNCED;
            end
            ssp_pkg::ST_SYNCED: state_next = ssp_pkg::ST_SYNCED;
            default:            state_next = ssp_pkg::ST_NORMAL;
        endcase
        if (!mode_ok) begin
            state_next = ssp_pkg::ST_NORMAL;                                 // R7
        end
        // a missed sleep broadcast leaves the phase untouched
        if (!mode_ok || sync_pt) begin
            phase_next = 17'h0_0000;                                         // R3
        end else if (tick) begin
            phase_next = phase_reg + 17'h0_0001;
        end
        // set wins over the clear at the sync point
        if (sync_pt) begin
            early_next = 1'b0;                                               // R2
        end
        if (imm_ok || (rx_msg.sleep_now && awake && synced && mode_cyc)) begin
            early_next = 1'b1;                                               // R1
        end
        if (!mode_ok) begin
            nom_next = 1'b0;
        end else if (btn_double) begin
            nom_next = 1'b1;                                                 // R13
        end
        if (forced_reg != 15'h0000 && tick) begin
            forced_next = forced_reg - 15'h0001;
        end
        if (mode_ok && (btn_long || (btn_single && synced && !awake))) begin
            forced_next = `SSP_AWAKE_HOLD_MS;                                // R16 R20 R21
        end
        tx_next.sync       = mode_ok & synced & ((period_end & coord)
                             | (rx_msg.sync_req & awake));                   // R18 R13
        tx_next.sync_req   = mode_ok & (state_reg == ssp_pkg::ST_SEARCH) & period_end; // R17
        tx_next.sleep_now  = imm_ok;                                         // R1
        tx_next.sleep_period = sp_reg;
        tx_next.wake_time    = st_eff;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg  <= ssp_pkg::ST_NORMAL;
            phase_reg  <= 17'h0_0000;
            early_reg  <= 1'b0;
            nom_reg    <= 1'b0;
            forced_reg <= 15'h0000;
            tx_reg     <= '0;
            txen_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            phase_reg  <= phase_next;
            early_reg  <= early_next;
            nom_reg    <= nom_next;
            forced_reg <= forced_next;
            tx_reg     <= tx_next;
            txen_reg   <= awake;                                             // R6
        end
    end

    assign tx_msg    = tx_reg;
    assign tx_enable = txen_reg;

    // ==================================================
    // commissioning button: short, double and long presses
    always_comb begin
        hold_next  = hold_reg;
        press_next = press_reg;
        gap_next   = gap_reg;
        btn_long   = 1'b0;
        btn_single = 1'b0;
        btn_double = 1'b0;
        if (commission_btn && !btn_prev_reg) begin
            hold_next = 12'h000;
        end else if (commission_btn && tick && hold_reg < `SSP_LONG_PRESS_MS) begin
            hold_next = hold_reg + 12'h001;
            btn_long  = hold_reg == `SSP_LONG_PRESS_MS - 12'h001;            // R20
        end
        if (press_reg != 2'b00 && tick) begin
            gap_next = gap_reg + 9'h001;
            if (gap_reg == `SSP_DOUBLE_GAP_MS - 9'h001) begin
                btn_single = 1'b1;                                           // R16
                press_next = 2'b00;
            end
        end
        if (!commission_btn && btn_prev_reg && hold_reg < `SSP_LONG_PRESS_MS) begin
            gap_next = 9'h000;
            if (press_reg != 2'b00) begin
                btn_double = 1'b1;                                           // R13
                btn_single = 1'b0;
                press_next = 2'b00;
            end else begin
                press_next = 2'b01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            btn_prev_reg <= 1'b0;
            hold_reg     <= 12'h000;
            press_reg    <= 2'b00;
            gap_reg      <= 9'h000;
        end else begin
            btn_prev_reg <= commission_btn;
            hold_reg     <= hold_next;
            press_reg    <= press_next;
            gap_reg      <= gap_next;
        end
    end

    // ==================================================
    // sleep indicator pin and association led
    assign blink_on = coord | (synced & awake);                              // R14 R15
    assign led_lim  = coord ? `SSP_LED_SLOW_MS : `SSP_LED_FAST_MS;           // R14

    always_comb begin
        pulse_next   = pulse_reg;
        led_cnt_next = led_cnt_reg;
        led_next     = led_reg;
        if (pulse_reg != 6'h00) begin
            pulse_next = pulse_reg - 6'h01;
        end
        if (sync_pt && mode_ok && (synced || adopt)) begin
            pulse_next = 6'(`SSP_PULSE_LOW_CYC);                             // R4 R24 R6
        end
        case (ctrl_reg.sleep_pin_function)
            `SSP_PINF_PULSE:    pin_next = !mode_ok || (pulse_next == 6'h00); // R4 R5
            `SSP_PINF_ON_SLEEP: pin_next = awake;                            // R5
            default:            pin_next = 1'b0;
        endcase
        if (!blink_on) begin
            led_cnt_next = 10'h000;
            led_next     = 1'b0;
        end else if (tick) begin
            if (led_cnt_reg >= led_lim - 10'h001) begin
                led_cnt_next = 10'h000;
                led_next     = !led_reg;
            end else begin
                led_cnt_next = led_cnt_reg + 10'h001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_reg   <= 6'h00;
            pin_reg     <= 1'b0;
            led_reg     <= 1'b0;
            led_cnt_reg <= 10'h000;
        end else begin
            pulse_reg   <= pulse_next;
            pin_reg     <= pin_next;
            led_reg     <= led_next;
            led_cnt_reg <= led_cnt_next;
        end
    end

    assign sleep_indicator_pin = pin_reg;
    assign assoc_led           = led_reg;

    // ==================================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_sleep_immediate: assert property (imm_ok |=> tx_msg.sleep_now && !awake) // R1
        else $error("sleep immediate did not sleep and broadcast");
    a_early_cleared: assert property (sync_pt && !imm_ok |=> !early_reg) // R2
        else $error("early sleep outlived the cycle");
    a_mode_gate: assert property (!mode_ok |=> !tx_msg.sync && !tx_msg.sync_req) // R7
        else $error("sync traffic outside modes 7 and 8");
    a_sp_zero_awake: assert property (synced && sp0 |-> awake) // R8
        else $error("node slept with sleep period zero");
    a_support_awake: assert property (mode_sup |-> awake) // R19
        else $error("support node asleep");
    a_wake_floor: assert property (st_eff >= minw_reg && st_eff >= st_reg) // R9
        else $error("wake time below traversal minimum");
    a_req_reply: assert property (rx_msg.sync_req && awake && synced && mode_ok
                                  |=> tx_msg.sync) // R18
        else $error("sync request not answered");
    a_sync_adopt: assert property (adopt |=> sp_reg == $past(rx_msg.sleep_period)
                                   && synced) // R22
        else $error("received sync not adopted");
    a_pulse_shape: assert property (sync_pt && mode_ok && synced
        && ctrl_reg.sleep_pin_function == `SSP_PINF_PULSE && !(sync_pt && !mode_ok)
        |=> !sleep_indicator_pin [*8] ##PULSE_HI_DLY sleep_indicator_pin) // R4 R24
        else $error("sync pulse low phase wrong");
    a_search_req: assert property (state_reg == ssp_pkg::ST_SEARCH && period_end
                                   && mode_ok |=> tx_msg.sync_req) // R17
        else $error("unsynced node skipped sync request");
    a_pin_onsleep: assert property (ctrl_reg.sleep_pin_function == `SSP_PINF_ON_SLEEP
        && $stable(ctrl_reg) |=> sleep_indicator_pin == $past(awake)) // R5
        else $error("on-sleep indicator wrong");

    c_sleep_imm:  cover property (imm_ok ##1 tx_msg.sleep_now);
    c_pulse:      cover property (sync_pt && ctrl_reg.sleep_pin_function == `SSP_PINF_PULSE);
    c_double:     cover property (btn_double ##1 nom_reg);
    c_long_press: cover property (btn_long);

endmodule // ssp_top

//--- hdl/ssp_defines.svh
// offsets, field values and timing constants of the sync sleep pulse controller
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

// ==================================================
// register byte offsets
`define SSP_ADDR_CTRL        8'h00
`define SSP_ADDR_SLEEP_PER   8'h04
`define SSP_ADDR_WAKE_TIME   8'h08
`define SSP_ADDR_MIN_WAKE    8'h0c
`define SSP_ADDR_CMD         8'h10
`define SSP_ADDR_STATUS      8'h14

// ==================================================
// field values
`define SSP_MODE_SUPPORT     4'h7
`define SSP_MODE_CYCLIC      4'h8
`define SSP_PINF_ON_SLEEP    4'h1
`define SSP_PINF_PULSE       4'h6
`define SSP_CMD_SLEEP_BIT    0
`define SSP_RST_MIN_WAKE     16'h0064

// ==================================================
// timing: the time in its unit, then derived cycle counts
`define SSP_CLK_PERIOD_NS    25
`define SSP_TICK_NS          1000000
`define SSP_TICK_CYCLES      (`SSP_TICK_NS / `SSP_CLK_PERIOD_NS)
`define SSP_PULSE_LOW_NS     1000
`define SSP_PULSE_LOW_CYC    ((`SSP_PULSE_LOW_NS + `SSP_CLK_PERIOD_NS - 1) / `SSP_CLK_PERIOD_NS)
`define SSP_LONG_PRESS_MS    12'h07d0
`define SSP_DOUBLE_GAP_MS    9'h01f4
`define SSP_AWAKE_HOLD_MS    15'h7530
`define SSP_LED_SLOW_MS      10'h03e8
`define SSP_LED_FAST_MS      10'h00fa

`endif

//--- hdl/ssp_pkg.sv
// types of the sync sleep pulse controller
package ssp_pkg;

    // ==================================================
    // software controls
    typedef struct packed {
        logic       pref_coord;
        logic [3:0] sleep_pin_function;
        logic [3:0] sleep_mode_select;
    } ssp_ctrl_t;

    // ==================================================
    // one peer message; flags are one-cycle pulses
    typedef struct packed {
        logic        sync;
        logic        sync_req;
        logic        sleep_now;
        logic [15:0] sleep_period;
        logic [15:0] wake_time;
    } ssp_msg_t;

    // ==================================================
    // node state
    typedef enum logic [2:0] {
        ST_NORMAL = 3'b001,
        ST_SEARCH = 3'b010,
        ST_SYNCED = 3'b100
    } ssp_state_t;

endpackage

//--- verif/ssp_peer.sv
// peer node model: answers each sync request with a sync carrying its cycle
`timescale 1ns/1ps
module ssp_peer #(
    // long enough that the scaled cycle outlasts the 40-clock sync pulse
    parameter logic [15:0] PEER_SP = 16'h0014,
    parameter logic [15:0] PEER_ST = 16'h0004
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // stimulus: ask for a sync, as a joining node would
    input  wire logic              ask,
    // radio side
    input  wire ssp_pkg::ssp_msg_t tx_msg,
    output ssp_pkg::ssp_msg_t      rx_msg
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_msg <= '0;
        end else if (tx_msg.sync_req) begin
            rx_msg <= '{1'b1, 1'b0, 1'b0, PEER_SP, PEER_ST};
        end else if (ask) begin
            rx_msg <= '{1'b0, 1'b1, 1'b0, rx_msg.sleep_period, rx_msg.wake_time};
        end else begin
            // fields mean nothing outside a sync, so keep them moving
            rx_msg <= '{1'b0, 1'b0, 1'b0, ~rx_msg.sleep_period, ~rx_msg.wake_time};
        end
    end
endmodule // ssp_peer

//--- verif/ssp_top_tb.sv
// self-checking bench of the sync sleep pulse controller
`timescale 1ns/1ps
`include "ssp_defines.svh"
module ssp_top_tb;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic              led, pin, tx_en, e, btn, ask;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, r;
    ssp_pkg::ssp_msg_t rx_msg, tx_msg;
    int                bad_count, n_checks, n_sleep, n_sync, n_req, n, c0;
    typedef struct packed {
        logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;
    } ssp_row_t;
    localparam ssp_row_t ROWS [10] = '{
        '{0, `SSP_ADDR_CTRL, '0, '0, 0}, '{0, `SSP_ADDR_MIN_WAKE, '0, 32'h0064, 0},
        '{1, `SSP_ADDR_MIN_WAKE, 32'h0002, '0, 0}, '{1, `SSP_ADDR_WAKE_TIME, 32'h0001, '0, 0},
        '{0, `SSP_ADDR_WAKE_TIME, '0, 32'h0002, 0}, '{1, `SSP_ADDR_WAKE_TIME, 32'h0005, '0, 0},
        '{0, `SSP_ADDR_WAKE_TIME, '0, 32'h0005, 0}, '{1, `SSP_ADDR_SLEEP_PER, 32'h0003, '0, 0},
        '{0, `SSP_ADDR_SLEEP_PER, '0, 32'h0003, 0}, '{0, 8'h1c, '0, '0, 1}};
    ssp_top #(.MS_CYCLES(4)) i_ssp_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_msg(rx_msg), .tx_msg(tx_msg),
        .tx_enable(tx_en), .commission_btn(btn), .assoc_led(led), .sleep_indicator_pin(pin));
    ssp_peer i_ssp_peer (.pclk(pclk), .presetn(presetn), .ask(ask), .tx_msg(tx_msg),
        .rx_msg(rx_msg));
    // ==================================================
    // tasks
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic give_up;
        bad_count++;
        tally_and_finish();
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k == 20) give_up();
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_stat(input int b, input logic v);
        int k;
        for (k = 0; k < 300 && r[b] !== v; k++) apb(0, `SSP_ADDR_STATUS, '0);
        if (k == 300) give_up();
    endtask
    // clocks between two led toggles; the first toggle only sets the start
    task automatic led_gap(output int k);
        logic l;
        l = led;
        for (k = 0; k < 9000 && led === l; k++) @(posedge pclk);
        l = led;
        for (k = 0; k < 9000 && led === l; k++) @(posedge pclk);
    endtask
    always @(posedge pclk) begin
        n_sleep <= n_sleep + int'(tx_msg.sleep_now === 1'b1);
        n_sync <= n_sync + int'(tx_msg.sync === 1'b1);
        n_req <= n_req + int'(tx_msg.sync_req === 1'b1);
    end
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // ==================================================
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, r, btn, ask} = '0;
        {bad_count, n_checks, n_sleep, n_sync, n_req} = '0;
        repeat (10) @(posedge pclk);
        chk({pin, led, tx_en, tx_msg.sync, tx_msg.sync_req, tx_msg.sleep_now}, '0);
        chk({tx_msg.sleep_period, tx_msg.wake_time}, '0);
        presetn <= 1'b1;
        foreach (ROWS[i]) begin
            apb(ROWS[i].w, ROWS[i].a, ROWS[i].d);
            if (!ROWS[i].w) chk(r, ROWS[i].x);
            chk(e, ROWS[i].e);
        end
        $display("test registers done");
        apb(1, `SSP_ADDR_CTRL, 32'h0008);
        r = '0;
        wait_stat(1, 1'b1);
        chk(n_req > 0, 1);
        apb(0, `SSP_ADDR_SLEEP_PER, '0);
        chk(r, 32'h0014);
        apb(0, `SSP_ADDR_WAKE_TIME, '0);
        chk(r, 32'h0004);
        $display("test join done");
        wait_stat(0, 1'b1);
        c0 = n_sleep;
        apb(1, `SSP_ADDR_CMD, 32'h0001);
        repeat (3) @(posedge pclk);
        chk(n_sleep - c0, 1);
        chk(tx_en, 0);
        wait_stat(0, 1'b1);
        $display("test sleep now done");
        apb(1, `SSP_ADDR_CTRL, 32'h0068);
        for (n = 0; n < 2000 && pin !== 1'b1; n++) @(posedge pclk);
        if (n == 2000) give_up();
        for (n = 0; n < 2000 && pin !== 1'b0; n++) @(posedge pclk);
        if (n == 2000) give_up();
        for (n = 0; n < 100 && pin === 1'b0; n++) @(posedge pclk);
        chk(n, `SSP_PULSE_LOW_CYC);
        $display("test pulse done");
        apb(1, `SSP_ADDR_CTRL, 32'h0168);
        r = '0;
        wait_stat(2, 1'b1);
        c0 = n_sync;
        repeat (200) @(posedge pclk);
        chk(n_sync > c0, 1);
        led_gap(n);
        chk(n, `SSP_LED_SLOW_MS * 4);
        $display("test coordinator done");
        apb(1, `SSP_ADDR_CTRL, 32'h0017);
        repeat (5) @(posedge pclk);
        chk(pin, 1);
        c0 = n_sync;
        ask <= 1'b1;
        @(posedge pclk);
        ask <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(n_sync - c0, 1);
        led_gap(n);
        chk(n, `SSP_LED_FAST_MS * 4);
        btn <= 1'b1;
        repeat (4) @(posedge pclk);
        btn <= 1'b0;
        repeat (20) @(posedge pclk);
        btn <= 1'b1;
        repeat (4) @(posedge pclk);
        btn <= 1'b0;
        apb(0, `SSP_ADDR_STATUS, '0);
        chk(r[2:0], 3'b111);
        apb(1, `SSP_ADDR_CTRL, 32'h0008);
        btn <= 1'b1;
        repeat (`SSP_LONG_PRESS_MS * 4 + 8) @(posedge pclk);
        btn <= 1'b0;
        apb(0, `SSP_ADDR_STATUS, '0);
        chk(r[3:0], 4'hf);
        $display("test button done");
        apb(1, `SSP_ADDR_CTRL, 32'h0010);
        apb(0, `SSP_ADDR_STATUS, '0);
        chk(r[1:0], 2'b01);
        $display("test modes done");
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `SSP_ADDR_STATUS, '0);
        chk(r[3:0], 4'h1);
        $display("test reset done");
        tally_and_finish();
    end
endmodule // ssp_top_tb
